/* common/spisf_cfg.svh */
`ifndef SPISF_CFG_SVH
`define SPISF_CFG_SVH

// ******************************************************
// register offsets
// ******************************************************
`define SPISF_ADDR_W          4
`define SPISF_OFS_CTRL1       4'h0
`define SPISF_OFS_CTRL2       4'h1
`define SPISF_OFS_STATUS      4'h3
`define SPISF_OFS_DATA_HI     4'h4
`define SPISF_OFS_DATA_LO     4'h5
`define SPISF_OFS_MATCH_HI    4'h6
`define SPISF_OFS_MATCH_LO    4'h7
`define SPISF_OFS_IRQ_MASK    4'h8
`define SPISF_OFS_IRQ_STATUS  4'h9

// ******************************************************
// field positions
// ******************************************************
`define SPISF_ST_RX_FULL      7
`define SPISF_ST_MATCH        6
`define SPISF_ST_TX_EMPTY     5
`define SPISF_ST_MODE_FAULT   4
`define SPISF_C1_MASTER       4
`define SPISF_C1_SEL_OUT_EN   1
`define SPISF_C2_FAULT_EN     4
`define SPISF_C2_FIFO_EN      0
`define SPISF_IRQ_RX_FULL     0
`define SPISF_IRQ_MATCH       1
`define SPISF_IRQ_TX_EMPTY    2
`define SPISF_IRQ_MODE_FAULT  3

// ******************************************************
// reset values
// ******************************************************
`define SPISF_RST_BYTE        8'h00
`define SPISF_RST_IRQ         4'h0
`define SPISF_RST_SYNC        1'h1

`endif

/* common/spisf_pkg.sv */
package spisf_pkg;

    // ******************************************************
    // register port request
    // ******************************************************
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } spisf_bus_s;

    typedef logic [7:0] spisf_byte_t;

endpackage

/* rtl/spisf_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spisf_cfg.svh"

module spisf_sync (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);

    logic [1:0] stage;
    logic [1:0] next_stage;

    always_comb
    begin
        next_stage = {stage[0], din};
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stage <= {2{`SPISF_RST_SYNC}};
        end
        else
        begin
            stage <= next_stage;
        end
    end

    assign dout = stage[1];

endmodule
`default_nettype wire

/* rtl/spisf_top.sv */
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "spisf_cfg.svh"

module spisf_top #(
    parameter int FIFO_DEPTH = 4,
    parameter int DATA_W     = 16
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire spisf_pkg::spisf_bus_s bus,
    output logic [7:0]                rdata,
    output logic                      irq,
    input  wire logic                 ss_n_pin,
    input  wire logic                 shift_busy,
    input  wire logic                 shift_done,
    input  wire logic [DATA_W-1:0]    rx_word,
    output logic                      tx_load,
    output logic [DATA_W-1:0]         tx_word
);

    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    // ******************************************************
    // state
    // ******************************************************
    typedef struct packed {
        logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
        logic [PW-1:0]                     wr_ptr;
        logic [PW-1:0]                     rd_ptr;
        logic [CW-1:0]                     count;
        spisf_pkg::spisf_byte_t            ctrl1;
        spisf_pkg::spisf_byte_t            ctrl2;
        spisf_pkg::spisf_byte_t            tx_high;
        logic [DATA_W-1:0]                 rx_buf;
        logic [DATA_W-1:0]                 match_val;
        logic                              rx_full;
        logic                              match_flag;
        logic                              mode_fault;
        logic                              tx_filled_q;
        logic                              arm_rx;
        logic                              arm_match;
        logic                              arm_tx;
        logic                              arm_fault;
        logic [3:0]                        irq_status;
        logic [3:0]                        irq_mask;
        spisf_pkg::spisf_byte_t            rdata;
        logic                              irq;
        logic                              tx_load;
        logic [DATA_W-1:0]                 tx_word;
    } spisf_state_s;

    spisf_state_s s;
    spisf_state_s next_s;

    logic ss_n_sync;
    logic fifo_on;
    logic tx_empty;
    logic fault_detect;
    logic capacity_free;
    logic data_write;
    logic push;
    logic pop;
    logic rx_set;
    logic match_set;
    logic fault_set;
    logic tx_empty_rise;
    logic [3:0] irq_events;
    spisf_pkg::spisf_byte_t status_byte;
    spisf_pkg::spisf_byte_t read_mux;

    // ******************************************************
    // pin synchroniser
    // ******************************************************
    // select pin idles high; the synchroniser resets to that level
    spisf_sync u_ss_sync (
        .clk   (clk),
        .reset (reset),
        .din   (ss_n_pin),
        .dout  (ss_n_sync)
    );

    // ******************************************************
    // derived conditions
    // ******************************************************
    always_comb
    begin
        fifo_on  = s.ctrl2[`SPISF_C2_FIFO_EN];
        // flag is empty-buffer or empty-fifo depending on mode
        tx_empty = (s.count == '0);
        fault_detect = s.ctrl1[`SPISF_C1_MASTER]
                     & s.ctrl2[`SPISF_C2_FAULT_EN]
                     & ~s.ctrl1[`SPISF_C1_SEL_OUT_EN];
        fault_set = fault_detect & ~ss_n_sync;
        // single-buffer mode holds one word, fifo mode the whole depth
        // switching fifo_enable does not flush words already queued
        if (fifo_on)
        begin
            capacity_free = (s.count < CW'(FIFO_DEPTH));
        end
        else
        begin
            capacity_free = (s.count == '0);
        end
        data_write = bus.wr & (bus.addr == `SPISF_OFS_DATA_LO);
        if (fifo_on)
        begin
            push = data_write & capacity_free;
        end
        else
        begin
            push = data_write & capacity_free & s.arm_tx;
        end
        // load the shifter when idle, one pulse per word
        pop = (s.count != '0) & ~shift_busy & ~s.tx_load;
        rx_set    = shift_done & ~fifo_on;
        match_set = rx_set & (rx_word == s.match_val);
        // kept as "not empty" so the all-zero reset state reads as empty
        // and no false rising edge is reported right after reset
        tx_empty_rise = tx_empty & s.tx_filled_q;
        irq_events = '0;
        irq_events[`SPISF_IRQ_RX_FULL]    = rx_set;
        irq_events[`SPISF_IRQ_MATCH]      = match_set;
        irq_events[`SPISF_IRQ_TX_EMPTY]   = tx_empty_rise;
        irq_events[`SPISF_IRQ_MODE_FAULT] = fault_set;
    end

    // ******************************************************
    // read mux
    // ******************************************************
    always_comb
    begin
        // unused status bits read as zero
        status_byte = `SPISF_RST_BYTE;
        status_byte[`SPISF_ST_RX_FULL]    = s.rx_full;
        status_byte[`SPISF_ST_MATCH]      = s.match_flag;
        status_byte[`SPISF_ST_TX_EMPTY]   = tx_empty;
        status_byte[`SPISF_ST_MODE_FAULT] = s.mode_fault;
        unique case (bus.addr)
            `SPISF_OFS_CTRL1:      read_mux = s.ctrl1;
            `SPISF_OFS_CTRL2:      read_mux = s.ctrl2;
            `SPISF_OFS_STATUS:     read_mux = status_byte;
            `SPISF_OFS_DATA_HI:    read_mux = s.rx_buf[DATA_W-1 -: 8];
            `SPISF_OFS_DATA_LO:    read_mux = s.rx_buf[7:0];
            `SPISF_OFS_MATCH_HI:   read_mux = s.match_val[DATA_W-1 -: 8];
            `SPISF_OFS_MATCH_LO:   read_mux = s.match_val[7:0];
            `SPISF_OFS_IRQ_MASK:   read_mux = {4'h0, s.irq_mask};
            `SPISF_OFS_IRQ_STATUS: read_mux = {4'h0, s.irq_status};
            default:               read_mux = `SPISF_RST_BYTE;
        endcase
    end

    // ******************************************************
    // next state
    // ******************************************************
    always_comb
    begin
        next_s = s;
        next_s.tx_filled_q = ~tx_empty;
        next_s.rdata      = bus.rd ? read_mux : `SPISF_RST_BYTE;
        next_s.tx_load    = pop;

        // plain control, data-high, match and interrupt mask registers
        if (bus.wr)
        begin
            unique case (bus.addr)
                `SPISF_OFS_CTRL1:    next_s.ctrl1 = bus.wdata;
                `SPISF_OFS_CTRL2:    next_s.ctrl2 = bus.wdata;
                `SPISF_OFS_DATA_HI:  next_s.tx_high = bus.wdata;
                `SPISF_OFS_MATCH_HI: next_s.match_val[DATA_W-1 -: 8] = bus.wdata;
                `SPISF_OFS_MATCH_LO: next_s.match_val[7:0] = bus.wdata;
                `SPISF_OFS_IRQ_MASK: next_s.irq_mask = bus.wdata[3:0];
                default:             next_s = next_s;
            endcase
        end

        // transmit buffer / fifo
        if (push)
        begin
            next_s.mem[s.wr_ptr] = DATA_W'({s.tx_high, bus.wdata});
            next_s.wr_ptr = (s.wr_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : s.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_s.tx_word = s.mem[s.rd_ptr];
            next_s.rd_ptr = (s.rd_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
        end
        if (push & ~pop)
        begin
            next_s.count = s.count + 1'b1;
        end
        else if (pop & ~push)
        begin
            next_s.count = s.count - 1'b1;
        end

        // armed bits: a status read samples each flag
        // a read that sees a flag clear disarms it, so a stale arm never clears
        if (bus.rd & (bus.addr == `SPISF_OFS_STATUS))
        begin
            next_s.arm_rx    = s.rx_full;
            next_s.arm_match = s.match_flag;
            next_s.arm_tx    = tx_empty;
            next_s.arm_fault = s.mode_fault;
        end
        if (data_write)
        begin
            next_s.arm_tx = 1'b0;
        end

        // receive-full: armed read of the low data byte clears it
        if (bus.rd & (bus.addr == `SPISF_OFS_DATA_LO) & s.arm_rx)
        begin
            next_s.rx_full = 1'b0;
            next_s.arm_rx  = 1'b0;
        end
        if (rx_set)
        begin
            next_s.rx_full = 1'b1;
            next_s.rx_buf  = rx_word;
        end

        // match flag: armed write of one clears, new match wins
        if (bus.wr & (bus.addr == `SPISF_OFS_STATUS))
        begin
            if (s.arm_match & bus.wdata[`SPISF_ST_MATCH])
            begin
                next_s.match_flag = 1'b0;
            end
            next_s.arm_match = 1'b0;
        end
        if (match_set)
        begin
            next_s.match_flag = 1'b1;
        end

        // mode fault: armed write of control one clears, new fault wins
        // a select pin still low sets the flag again after the clear
        if (bus.wr & (bus.addr == `SPISF_OFS_CTRL1))
        begin
            if (s.arm_fault)
            begin
                next_s.mode_fault = 1'b0;
            end
            next_s.arm_fault = 1'b0;
        end
        if (fault_set)
        begin
            next_s.mode_fault = 1'b1;
        end

        // interrupt status: write one to clear, set wins
        // interrupt output moves on the same edge as the status bits
        if (bus.wr & (bus.addr == `SPISF_OFS_IRQ_STATUS))
        begin
            next_s.irq_status = s.irq_status & ~bus.wdata[3:0];
        end
        next_s.irq_status = next_s.irq_status | irq_events;
        next_s.irq = |(next_s.irq_status & next_s.irq_mask);
    end

    // ******************************************************
    // state register
    // ******************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ******************************************************
    // outputs
    // ******************************************************
    assign rdata   = s.rdata;
    assign irq     = s.irq;
    assign tx_load = s.tx_load;
    assign tx_word = s.tx_word;

endmodule
`default_nettype wire

/* dv/spisf_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module spisf_monitor #(
    parameter int FIFO_DEPTH = 4,
    parameter int DATA_W     = 16
) (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire spisf_pkg::spisf_bus_s bus,
    input wire logic [7:0]            rdata,
    input wire logic                  irq,
    input wire logic                  ss_n_pin,
    input wire logic                  shift_busy,
    input wire logic                  shift_done,
    input wire logic [DATA_W-1:0]     rx_word,
    input wire logic                  tx_load,
    input wire logic [DATA_W-1:0]     tx_word
);
    logic [7:0]  c1;
    logic [7:0]  c2;
    logic [7:0]  msk;
    logic [15:0] mv;
    logic        st_q;
    logic        arm;
    wire logic   arm_now = arm | (st_q & rdata[5]);
    wire logic   flt     = c1[4] & ~c1[1] & c2[4];

    // ******************************************************
    // shadow of software writes
    // ******************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            c1   <= 8'h00;
            c2   <= 8'h00;
            msk  <= 8'h00;
            mv   <= 16'h0000;
            st_q <= 1'b0;
            arm  <= 1'b0;
        end
        else
        begin
            st_q <= bus.rd && bus.addr == 4'h3;
            if (bus.wr && bus.addr == 4'h5)
                arm <= 1'b0;
            else if (st_q)
                arm <= rdata[5];
            if (bus.wr)
                case (bus.addr)
                    4'h0: c1 <= bus.wdata;
                    4'h1: c2 <= bus.wdata;
                    4'h6: mv[15:8] <= bus.wdata;
                    4'h7: mv[7:0] <= bus.wdata;
                    4'h8: msk <= bus.wdata;
                    default: ;
                endcase
        end
    end

    // ******************************************************
    // properties
    // ******************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_rdata_idle;
        !$past(bus.rd) |-> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata without read");
    property p_load_gap;
        tx_load |=> !tx_load;
    endproperty
    a_load_gap: assert property (p_load_gap) else $error("tx_load too long");
    property p_word_hold;
        !tx_load |-> $stable(tx_word);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("tx_word moved");
    property p_load_free;
        tx_load |-> !$past(shift_busy);
    endproperty
    a_load_free: assert property (p_load_free) else $error("load while busy");
    property p_idle_load;
        bus.wr && bus.addr == 4'h5 && arm_now && !c2[0] && !shift_busy && !tx_load
            |-> ##2 tx_load && tx_word[7:0] == $past(bus.wdata, 2);
    endproperty
    a_idle_load: assert property (p_idle_load) else $error("idle write not loaded");
    property p_full_irq;
        shift_done && !c2[0] && msk[0] |=> irq;
    endproperty
    a_full_irq: assert property (p_full_irq) else $error("no rx full irq");
    property p_match_irq;
        shift_done && !c2[0] && rx_word == mv && msk[1] |=> irq;
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("no match irq");
    property p_fault_irq;
        (flt && msk[3] && !ss_n_pin) [*4] |=> irq;
    endproperty
    a_fault_irq: assert property (p_fault_irq) else $error("no fault irq");
endmodule

bind spisf_top spisf_monitor #(.FIFO_DEPTH(FIFO_DEPTH), .DATA_W(DATA_W)) i_mon (
    .clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .irq(irq), .ss_n_pin(ss_n_pin),
    .shift_busy(shift_busy), .shift_done(shift_done), .rx_word(rx_word),
    .tx_load(tx_load), .tx_word(tx_word));
`default_nettype wire

/* dv/spisf_shifter_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spisf_shifter_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  len,
    input  wire logic        tx_load,
    input  wire logic [15:0] tx_word,
    output logic             shift_busy,
    output logic             shift_done,
    output logic [15:0]      rx_word
);
    logic [7:0]  cnt;
    logic [15:0] word;

    // echoes each word back; rx_word churns outside the done pulse
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt        <= 8'h00;
            word       <= 16'h0000;
            shift_busy <= 1'b0;
            shift_done <= 1'b0;
            rx_word    <= 16'h0000;
        end
        else
        begin
            shift_done <= 1'b0;
            rx_word    <= ~rx_word;
            if (tx_load)
            begin
                word       <= tx_word;
                cnt        <= len;
                shift_busy <= 1'b1;
            end
            else if (shift_busy && cnt == 8'h00)
            begin
                shift_busy <= 1'b0;
                shift_done <= 1'b1;
                rx_word    <= word;
            end
            else if (shift_busy)
                cnt <= cnt - 8'h01;
        end
    end
endmodule
`default_nettype wire

/* dv/spisf_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, reset, irq, ss_n_pin, shift_busy, shift_done, tx_load;
    logic [7:0]  rdata, len, rv;
    logic [15:0] rx_word, tx_word;
    logic [15:0] cfg [3] = '{16'h1210, 16'h1000, 16'h0010};
    spisf_pkg::spisf_bus_s bus;
    int bad_count, compares;

    spisf_top i_dut (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .irq(irq),
        .ss_n_pin(ss_n_pin), .shift_busy(shift_busy), .shift_done(shift_done),
        .rx_word(rx_word), .tx_load(tx_load), .tx_word(tx_word));
    spisf_shifter_model i_far (.clk(clk), .reset(reset), .len(len), .tx_load(tx_load),
        .tx_word(tx_word), .shift_busy(shift_busy), .shift_done(shift_done),
        .rx_word(rx_word));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 rv = rdata;
        @(posedge clk);
        chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rv & m});
    endtask
    task automatic st(input logic [7:0] m, input logic [7:0] exp);
        rd(4'h3, m, exp);
    endtask
    // sel 0 waits for a load, sel 1 for a finished transfer
    task automatic wait_ev(input logic sel);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end while ((sel ? shift_done : tx_load) !== 1'b1 && n < 100);
        if (n >= 100)
        begin
            bad_count++;
            $display("mismatch event expected 1 seen 0");
            stop_test();
        end
        @(posedge clk);
    endtask
    task automatic pulse_ss();
        ss_n_pin <= 1'b0;
        repeat (6) @(posedge clk);
        ss_n_pin <= 1'b1;
        @(posedge clk);
    endtask

    initial
    begin
        bad_count = 0;
        compares  = 0;
        reset     = 1'b1;
        bus       = '0;
        ss_n_pin  = 1'b1;
        len       = 8'h14;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        wr(4'h4, 8'h12);
        wr(4'h5, 8'h34);
        st(8'hff, 8'h20);
        chk("tx_word", 16'h0000, tx_word);
        $display("test unarmed write done");
        wr(4'h6, 8'h12);
        wr(4'h7, 8'h34);
        wr(4'h8, 8'h0b);
        wr(4'h4, 8'h12);
        wr(4'h5, 8'h34);
        st(8'h20, 8'h20);
        chk("tx_word", 16'h1234, tx_word);
        wr(4'h4, 8'h56);
        wr(4'h5, 8'h78);
        st(8'h20, 8'h00);
        wait_ev(1'b0);
        chk("tx_word", 16'h5678, tx_word);
        chk("irq", 16'h0001, {15'h0000, irq});
        st(8'he0, 8'he0);
        rd(4'h4, 8'hff, 8'h12);
        rd(4'h5, 8'hff, 8'h34);
        wr(4'h3, 8'h00);
        wr(4'h3, 8'h40);
        st(8'h40, 8'h40);
        wr(4'h3, 8'h40);
        st(8'hc0, 8'h00);
        $display("test single buffer done");
        wait_ev(1'b1);
        wr(4'h1, 8'h01);
        wr(4'h4, 8'ha1);
        wr(4'h5, 8'hb2);
        st(8'h20, 8'h20);
        chk("tx_word", 16'ha1b2, tx_word);
        wr(4'h4, 8'hc3);
        wr(4'h5, 8'hd4);
        st(8'h20, 8'h00);
        wr(4'h4, 8'he5);
        wr(4'h5, 8'hf6);
        wait_ev(1'b0);
        chk("tx_word", 16'hc3d4, tx_word);
        st(8'h20, 8'h00);
        wait_ev(1'b0);
        chk("tx_word", 16'he5f6, tx_word);
        st(8'h20, 8'h20);
        wait_ev(1'b1);
        $display("test fifo done");
        foreach (cfg[i])
        begin
            wr(4'h0, cfg[i][15:8]);
            wr(4'h1, cfg[i][7:0]);
            pulse_ss();
            st(8'h10, 8'h00);
        end
        rd(4'h9, 8'h0f, 8'h07);
        wr(4'h9, 8'h0f);
        chk("irq", 16'h0000, {15'h0000, irq});
        wr(4'h1, 8'h10);
        wr(4'h0, 8'h10);
        pulse_ss();
        st(8'h10, 8'h10);
        chk("irq", 16'h0001, {15'h0000, irq});
        wr(4'h0, 8'h10);
        st(8'h10, 8'h00);
        $display("test mode fault done");
        stop_test();
    end
endmodule
`default_nettype wire
